// ===== report_link_pkg.sv
/*
 Shared types and constants for the speed report link controller.
 Assumes a single 20 MHz clock domain and a synchronous active-low reset.
*/
package report_link_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned STREAM_RATE_HZ   = 10;
    localparam int unsigned STREAM_PERIOD_CYC = CLK_HZ / STREAM_RATE_HZ;

    // ------------------------------------------------------------------
    // Link identities and addressing
    // ------------------------------------------------------------------
    localparam logic [7:0] MASTER_ID    = 8'h01;
    localparam logic [7:0] SLAVE_ID     = 8'h02;
    localparam logic [7:0] POLL_ADDR    = 8'h02;
    localparam logic [7:0] ADDR_RESET   = 8'h02;

    // ------------------------------------------------------------------
    // Message formats
    // ------------------------------------------------------------------
    localparam logic [3:0] FMT_POLLED   = 4'hE;
    localparam logic [3:0] FMT_RESET    = 4'h1;

    // Request kinds from the controller
    typedef enum logic [1:0]
    {
        REQ_POLLED    = 2'h1,
        REQ_ADDRESSED = 2'h2
    } req_kind_t;

    // Request as decoded from the link
    typedef struct packed
    {
        req_kind_t  kind;
        logic [7:0] src_id;
        logic [7:0] dst_addr;
    } link_req_t;

    // Speed sample from the measurement core
    typedef struct packed
    {
        logic [7:0] strong_speed;
        logic [7:0] fast_speed;
        logic [7:0] vehicle_speed;
    } speed_sample_t;

    // Report handed to the serializer
    typedef struct packed
    {
        logic [3:0] format;
        logic [7:0] primary_speed;
        logic [7:0] fast_speed;
        logic [7:0] dst_id;
    } report_t;

    localparam int unsigned REPORT_W = $bits(report_t);

endpackage : report_link_pkg

// ===== report_fifo.sv
/*
 Holds no logic: the report queue module sits beside the controller in
 the controller's own file, so that one design file carries all logic.
 Assumes nothing of its surroundings.
*/

// ===== target_report_link_ctrl.sv
/*
 Decides when speed reports go out on the serial link: streaming or polled,
 point-to-point or multidrop. Reports queue in an 8-word FIFO before the
 serializer. Assumes requests arrive already decoded and checked, and that
 the serializer pulls reports with valid/ready.
*/
// What this block does
// - Speed samples are taken and reported only while the transmitter is on.
// - A point-to-point unit streams any format except the polled format, which is request-only.
// - With streaming in use and the transmitter on, reports go out at a fixed rate unprompted.
// - In polled mode each request that is accepted and queued gets exactly one polled-format report and nothing is unprompted.
// - The stationary variant puts its strong speed in the polled reply, others the vehicle speed.
// - A multidrop unit is only a slave and never transmits without a request to it.
// - A multidrop unit answers polled-format requests only when its address equals 2.
// - An addressed poll to the stationary multidrop unit returns one report in the current format.
// - Only the unit whose address matches an addressed poll sends a report back.
// - The controller uses master identifier 1 and the sensor slave identifier 2.
`timescale 1ns/1ps
module target_report_link_ctrl
    import report_link_pkg::*;
#(
    parameter int unsigned STREAM_PERIOD = STREAM_PERIOD_CYC,
    parameter int unsigned FIFO_DEPTH    = 8
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Configuration
    input  wire logic                          tx_on,
    input  wire logic                          multidrop,
    input  wire logic                          stationary,
    input  wire logic [3:0]                    out_format,
    input  wire logic [7:0]                    unit_addr,
    // Measurement core
    input  wire logic                          sample_valid,
    input  wire report_link_pkg::speed_sample_t sample,
    // Decoded requests
    input  wire logic                          req_valid,
    input  wire report_link_pkg::link_req_t    req,
    // Report output
    output logic                               rpt_valid,
    input  wire logic                          rpt_ready,
    output report_link_pkg::report_t           rpt,
    // Status
    output logic                               req_dropped
);
    import report_link_pkg::*;

    speed_sample_t latest_r;
    logic [31:0]   tick_cnt_r;
    logic          tick;
    logic          streaming;
    logic          polled_ok;
    logic          addressed_ok;
    logic          accept_req;
    logic          push_valid;
    logic          push_ready;
    report_t       push_rpt;
    logic          dropped_r;

    // Build one report in the given format
    function automatic report_t make_report(input speed_sample_t s,
                                            input logic [3:0]    fmt,
                                            input logic          stat);
        report_t r;
        r.format        = fmt;
        r.primary_speed = stat ? s.strong_speed : s.vehicle_speed;
        r.fast_speed    = s.fast_speed;
        r.dst_id        = MASTER_ID;
        return r;
    endfunction : make_report

    // ------------------------------------------------------------------
    // Speed capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            latest_r <= '0;
        end
        else if (!tx_on)
        begin
            latest_r <= '0;
        end
        else if (sample_valid)
        begin
            latest_r <= sample;
        end
    end

    // ------------------------------------------------------------------
    // Stream rate timer
    // ------------------------------------------------------------------
    assign streaming = tx_on && !multidrop && (out_format != FMT_POLLED);

    always_ff @(posedge clk)
    begin
        if (!nrst || !streaming)
        begin
            tick_cnt_r <= '0;
        end
        else if (tick_cnt_r == 32'(STREAM_PERIOD - 1))
        begin
            tick_cnt_r <= '0;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    assign tick = streaming && (tick_cnt_r == 32'(STREAM_PERIOD - 1));

    // ------------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------------
    assign polled_ok = (req.kind == REQ_POLLED)
                    && (out_format == FMT_POLLED)
                    && (!multidrop || unit_addr == POLL_ADDR);
    assign addressed_ok = (req.kind == REQ_ADDRESSED)
                    && multidrop && stationary
                    && (req.dst_addr == unit_addr);
    assign accept_req = req_valid && tx_on && (polled_ok || addressed_ok);

    // One report per accepted request or per tick; requests win the slot
    assign push_valid = accept_req || tick;
    assign push_rpt   = make_report(latest_r, out_format, stationary);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            dropped_r <= 1'b0;
        end
        else
        begin
            dropped_r <= req_valid && (!accept_req || !push_ready);
        end
    end

    assign req_dropped = dropped_r;

    // ------------------------------------------------------------------
    // Report queue
    // ------------------------------------------------------------------
    report_fifo #(
        .WIDTH (REPORT_W),
        .DEPTH (FIFO_DEPTH)
    ) report_fifo_inst (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_rpt),
        .out_valid (rpt_valid),
        .out_ready (rpt_ready),
        .out_data  (rpt)
    );

endmodule : target_report_link_ctrl

// ----------------------------------------------------------------------
// Report queue: synchronous FIFO, valid/ready on both sides
// ----------------------------------------------------------------------
module report_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Write side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Read side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // ------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'h1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'h1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'h1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'h1;
            end
        end
    end

endmodule : report_fifo

// ===== trl_chk.sv
/* Port checker for the report link controller.
   Assumes the bind in the bench top file. */
`timescale 1ns/1ps
module trl_chk
    import report_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration
    input wire logic tx_on,
    input wire logic multidrop,
    input wire logic stationary,
    input wire logic [3:0] out_format,
    input wire logic [7:0] unit_addr,
    // Samples and requests
    input wire logic sample_valid,
    input wire report_link_pkg::speed_sample_t sample,
    input wire logic req_valid,
    input wire report_link_pkg::link_req_t req,
    // Reports
    input wire logic rpt_valid,
    input wire logic rpt_ready,
    input wire report_link_pkg::report_t rpt,
    input wire logic req_dropped
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence poll_hit;
        req_valid && tx_on && !multidrop && req.kind == REQ_POLLED
        && out_format == FMT_POLLED && !rpt_valid;
    endsequence
    sequence addr_hit;
        req_valid && tx_on && multidrop && stationary && !rpt_valid
        && req.kind == REQ_ADDRESSED && req.dst_addr == unit_addr;
    endsequence
    tx_off_a: assert property (
        req_valid && !tx_on |=> req_dropped) else $error("poll with tx off kept");
    poll_ans_a: assert property (
        poll_hit |=> rpt_valid && rpt.format == FMT_POLLED) else $error("no poll reply");
    addr_ans_a: assert property (
        addr_hit |=> rpt_valid && rpt.format == out_format) else $error("no addressed reply");
    md_addr_a: assert property (
        req_valid && multidrop && req.kind == REQ_POLLED && unit_addr != POLL_ADDR
        |=> req_dropped) else $error("poll answered at wrong address");
    addr_miss_a: assert property (
        req_valid && req.kind == REQ_ADDRESSED
        && (req.dst_addr != unit_addr || !multidrop) |=> req_dropped)
        else $error("foreign addressed poll kept");
    no_unprompted_a: assert property (
        $rose(rpt_valid) && (multidrop || out_format == FMT_POLLED) |-> $past(req_valid))
        else $error("unprompted report");
    rpt_hold_a: assert property (
        rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt)) else $error("report lost");
    dst_id_a: assert property (
        rpt_valid |-> rpt.dst_id == MASTER_ID) else $error("bad destination id");
endmodule : trl_chk

// ===== rpt_sink.sv
/* Far-side controller model: takes reports, may stall.
   Assumes stall changes at the falling edge. */
`timescale 1ns/1ps
module rpt_sink
    import report_link_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     stall,
    input  wire logic                     rpt_valid,
    output logic                          rpt_ready,
    input  wire report_link_pkg::report_t rpt,
    output int                            n_got,
    output report_link_pkg::report_t      last
);
    always @(negedge clk)
        rpt_ready <= nrst && !stall;
    always @(posedge clk)
        if (!nrst)
        begin
            n_got <= 0;
        end
        else if (rpt_valid && rpt_ready)
        begin
            n_got <= n_got + 1;
            last  <= rpt;
        end
endmodule : rpt_sink

// ===== target_report_link_ctrl_bench.sv
/* Bench for the report link controller.
   Assumes the package, FIFO and checker are compiled first. */
`timescale 1ns/1ps
module target_report_link_ctrl_bench;
    import report_link_pkg::*;
    logic clk, nrst, tx_on, multidrop, stationary, sample_valid, req_valid;
    logic rpt_valid, rpt_ready, req_dropped, stall, dr;
    logic [3:0] out_format;
    logic [7:0] unit_addr;
    speed_sample_t sample;
    link_req_t req;
    report_t rpt, last;
    int n_got, n0, n_mismatch, tests_run;
    target_report_link_ctrl #(.STREAM_PERIOD(20)) target_report_link_ctrl_inst (.clk, .nrst,
        .tx_on, .multidrop, .stationary, .out_format, .unit_addr, .sample_valid, .sample,
        .req_valid, .req, .rpt_valid, .rpt_ready, .rpt, .req_dropped);
    rpt_sink rpt_sink_inst (.clk, .nrst, .stall, .rpt_valid, .rpt_ready, .rpt, .n_got, .last);
    always #25 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : check
    task automatic send(input req_kind_t k, input logic [7:0] d);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{k, MASTER_ID, d};
        @(negedge clk);
        req_valid = 1'b0;
        dr = req_dropped;
    endtask : send
    task automatic cfg(input logic md, input logic st, input logic [3:0] f, input logic [7:0] a);
        @(negedge clk);
        tx_on = 1'b0;
        repeat (4) @(negedge clk);
        {multidrop, stationary, out_format, unit_addr} = {md, st, f, a};
        tx_on = 1'b1;
        sample_valid = 1'b1;
        sample = '{8'h19, 8'h28, 8'h07};
        @(negedge clk);
        sample_valid = 1'b0;
        n0 = n_got;
    endtask : cfg
    task automatic t_poll;
        cfg(1'b0, 1'b1, FMT_POLLED, 8'h05);
        send(REQ_POLLED, 8'h00);
        repeat (3) @(negedge clk);
        check(n_got - n0, 1);
        check(last.primary_speed, 8'h19);
        check(last.fast_speed, 8'h28);
        check(last.format, FMT_POLLED);
        check(last.dst_id, MASTER_ID);
        repeat (45) @(negedge clk);
        check(n_got - n0, 1);
        send(REQ_ADDRESSED, 8'h05);
        check(dr, 1'b1);
        cfg(1'b0, 1'b0, FMT_POLLED, 8'h05);
        send(REQ_POLLED, 8'h00);
        repeat (3) @(negedge clk);
        check(last.primary_speed, 8'h07);
        tx_on = 1'b0;
        send(REQ_POLLED, 8'h00);
        check(dr, 1'b1);
        $display("poll test done");
    endtask : t_poll
    task automatic t_stream;
        cfg(1'b0, 1'b1, FMT_RESET, 8'h02);
        repeat (70) @(negedge clk);
        check(n_got - n0, 3);
        check(last.format, FMT_RESET);
        tx_on = 1'b0;
        n0 = n_got;
        repeat (60) @(negedge clk);
        check(n_got - n0, 0);
        $display("stream test done");
    endtask : t_stream
    task automatic t_multi;
        cfg(1'b1, 1'b1, FMT_POLLED, 8'h03);
        send(REQ_POLLED, 8'h00);
        check(dr, 1'b1);
        cfg(1'b1, 1'b1, 4'h3, POLL_ADDR);
        send(REQ_POLLED, 8'h00);
        check(dr, 1'b1);
        send(REQ_ADDRESSED, 8'h04);
        check(dr, 1'b1);
        send(REQ_ADDRESSED, POLL_ADDR);
        check(dr, 1'b0);
        repeat (50) @(negedge clk);
        check(n_got - n0, 1);
        check(last.format, 4'h3);
        out_format = FMT_POLLED;
        send(REQ_POLLED, 8'h00);
        check(dr, 1'b0);
        cfg(1'b1, 1'b0, 4'h3, POLL_ADDR);
        send(REQ_ADDRESSED, POLL_ADDR);
        check(dr, 1'b1);
        $display("multidrop test done");
    endtask : t_multi
    task automatic t_fifo;
        cfg(1'b0, 1'b1, FMT_POLLED, 8'h05);
        stall = 1'b1;
        repeat (9) send(REQ_POLLED, 8'h00);
        check(dr, 1'b1);
        check(n_got - n0, 0);
        stall = 1'b0;
        repeat (20) @(negedge clk);
        check(n_got - n0, 8);
        $display("fifo test done");
    endtask : t_fifo
    task automatic t_reset;
        cfg(1'b0, 1'b1, FMT_POLLED, 8'h05);
        stall = 1'b1;
        repeat (2) send(REQ_POLLED, 8'h00);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check(rpt_valid, 1'b0);
        check(req_dropped, 1'b0);
        @(negedge clk);
        check(rpt_valid, 1'b0);
        stall = 1'b0;
        repeat (5) @(negedge clk);
        check(n_got, 0);
        $display("reset test done");
    endtask : t_reset
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    initial
    begin
        {clk, nrst, tx_on, multidrop, stationary, sample_valid, req_valid, stall} = '0;
        {out_format, unit_addr, sample, req} = '0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        t_poll();
        t_stream();
        t_multi();
        t_fifo();
        t_reset();
        close_out();
    end
    initial
    begin
        #(50 * 3000);
        n_mismatch++;
        close_out();
    end
endmodule : target_report_link_ctrl_bench
bind target_report_link_ctrl trl_chk trl_chk_inst (.clk, .nrst, .tx_on, .multidrop,
    .stationary, .out_format, .unit_addr, .sample_valid, .sample, .req_valid, .req,
    .rpt_valid, .rpt_ready, .rpt, .req_dropped);
